// File: tccp_consts.svh
// Register offsets, field positions and reset values of the timer block
`ifndef TCCP_CONSTS_SVH
`define TCCP_CONSTS_SVH
`define TCCP_STS_ADDR 8'h00
`define TCCP_MASK_ADDR 8'h01
`define TCCP_UNIT_BASE 8'h10
`define TCCP_UNIT_STRIDE 8'h10
`define TCCP_CTRL_OFS 8'h00
`define TCCP_MOD_OFS 8'h01
`define TCCP_CNT_OFS 8'h02
`define TCCP_CH_BASE 8'h40
`define TCCP_CH_STRIDE 8'h02
`define TCCP_CHCTL_OFS 8'h00
`define TCCP_CHVAL_OFS 8'h01
`define TCCP_CTRL_CS_LSB 0
`define TCCP_CTRL_PS_LSB 2
`define TCCP_CTRL_CENTER_ALIGNED_PWM_BIT 5
`define TCCP_CHCTL_MODE_LSB 0
`define TCCP_CHCTL_CFG_LSB 2
`define TCCP_MOD_RST 16'h0000
`define TCCP_VAL_RST 16'h0000
`define TCCP_FULL_RANGE 16'hffff
`endif

// File: tccp_pkg.sv
// Types shared by the timer block
package tccp_pkg;
   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } tccp_bus_t;
   typedef enum logic [1:0] {CS_OFF, CS_BUS, CS_FIXED, CS_EXT} tccp_clksrc_t;
   typedef enum logic [1:0] {MD_CAPTURE, MD_COMPARE, MD_PWM, MD_PWM_ALT} tccp_chmode_t;
endpackage : tccp_pkg

// File: tccp_top.sv
// Two timer units (g_unit generate blocks) with capture, compare and PWM channels
`timescale 1ns/1ps
`include "tccp_consts.svh"
//
// Behaviour
// - Each unit times from own prescaled 16-bit counter
// - Two independent units: one and four channels
// - One bit per unit forces center-aligned PWM
// - Per-unit clock: bus, fixed, external pin
// - Prescaler divides by 1 to 128
// - Count up freely, or up/down when centered
// - Software 16-bit modulus bounds the counter
// - Per channel: capture, compare or edge PWM
// - Capture latches counter on chosen pin edge
// - Compare match sets, clears or toggles pin
// - PWM output polarity selectable per channel
// - Center-aligned PWM buffered on every channel
// - Interrupt per channel plus terminal count
// - Fixed clock is reference divided by two
// - One shared pin per channel
module tccp_top #(
   parameter int N_CH_A = 1,
   parameter int N_CH_B = 4,
   localparam int NCH = N_CH_A + N_CH_B
) (
   input wire logic CLK_IN,
   input wire logic RST_B_IN,
   input wire tccp_pkg::tccp_bus_t BUS_IN,
   output logic [15:0] RDATA_OUT,
   output logic IRQ_OUT,
   input wire logic FIXED_REF_IN,
   input wire logic [1:0] EXT_CLK_IN,
   input wire logic [NCH-1:0] CH_PIN_IN,
   output logic [NCH-1:0] CH_PIN_OUT,
   output logic [NCH-1:0] CH_PIN_OE_B_OUT
);
   import tccp_pkg::*;

   localparam int NIN = NCH + 3;
   localparam int NST = NCH + 2;
   logic [NST-1:0] sts_q;

   function automatic logic [7:0] unit_addr(input int u, input logic [7:0] ofs);
      return 8'(`TCCP_UNIT_BASE + u * `TCCP_UNIT_STRIDE) + ofs;
   endfunction : unit_addr

   function automatic logic [7:0] ch_addr(input int c, input logic [7:0] ofs);
      return 8'(`TCCP_CH_BASE + c * `TCCP_CH_STRIDE) + ofs;
   endfunction : ch_addr

   default clocking cb @(posedge CLK_IN);
   endclocking
   default disable iff (!RST_B_IN);

   ////////////////////////////////////////////////////////////////////////////
   // Pin synchronisers: channel pins, external clock pins, reference
   logic [NIN-1:0] raw;
   logic [2:0] sync_q [NIN];
   logic [NIN-1:0] lvl_q;
   logic [NIN-1:0] rise;
   logic [NIN-1:0] fall;

   assign raw = {FIXED_REF_IN, EXT_CLK_IN, CH_PIN_IN};

   generate
      for (genvar i = 0; i < NIN; i++) begin : g_sync
         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               sync_q[i] <= 3'h0;
            end else begin
               sync_q[i] <= {sync_q[i][1:0], raw[i]};
            end
         end
         // A change counts only once the last two stages agree
         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               lvl_q[i] <= 1'b0;
            end else if (sync_q[i][2] == sync_q[i][1]) begin
               lvl_q[i] <= sync_q[i][2];
            end
         end
         assign rise[i] = (sync_q[i][2] == sync_q[i][1]) && sync_q[i][2] && !lvl_q[i];
         assign fall[i] = (sync_q[i][2] == sync_q[i][1]) && !sync_q[i][2] && lvl_q[i];
      end
   endgenerate

   // Fixed clock tick: every second rising edge of the reference
   logic fix_div_q;
   logic fix_tick;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         fix_div_q <= 1'b0;
      end else if (rise[NCH+2]) begin
         fix_div_q <= !fix_div_q;
      end
   end
   assign fix_tick = rise[NCH+2] && fix_div_q;

   ////////////////////////////////////////////////////////////////////////////
   // Timer units
   logic [1:0] cs_q [2];
   logic [2:0] ps_q [2];
   logic center_aligned_pwm_q [2];
   logic [15:0] mod_buf_q [2];
   logic [15:0] mod_q [2];
   logic [15:0] cnt_q [2];
   logic up_q [2];
   logic [6:0] pre_q [2];
   logic upd_q [2];
   logic src_tick [2];
   logic tick [2];
   logic tof_ev [2];
   logic load [2];
   logic [15:0] lim [2];

   generate
      for (genvar u = 0; u < 2; u++) begin : g_unit
         localparam logic [7:0] A_CTRL = unit_addr(u, `TCCP_CTRL_OFS);
         localparam logic [7:0] A_MOD = unit_addr(u, `TCCP_MOD_OFS);
         localparam logic [7:0] A_CNT = unit_addr(u, `TCCP_CNT_OFS);
         logic [6:0] div_mask;
         logic cnt_clr;

         assign cnt_clr = BUS_IN.wr && BUS_IN.addr == A_CNT;

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               cs_q[u] <= 2'h0;
               ps_q[u] <= 3'h0;
               center_aligned_pwm_q[u] <= 1'b0;
            end else if (BUS_IN.wr && BUS_IN.addr == A_CTRL) begin
               cs_q[u] <= BUS_IN.wdata[`TCCP_CTRL_CS_LSB +: 2];
               ps_q[u] <= BUS_IN.wdata[`TCCP_CTRL_PS_LSB +: 3];
               center_aligned_pwm_q[u] <= BUS_IN.wdata[`TCCP_CTRL_CENTER_ALIGNED_PWM_BIT];
            end
         end

         always_comb begin
            unique case (tccp_clksrc_t'(cs_q[u]))
               CS_OFF: src_tick[u] = 1'b0;
               CS_BUS: src_tick[u] = 1'b1;
               CS_FIXED: src_tick[u] = fix_tick;
               CS_EXT: src_tick[u] = rise[NCH+u];
            endcase
         end

         // Prescaler taps 2^n, n from 0 to 7
         assign div_mask = 7'(8'(1) << ps_q[u]) - 7'h1;
         assign tick[u] = src_tick[u] && ((pre_q[u] & div_mask) == div_mask);

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               pre_q[u] <= 7'h0;
            end else if (cnt_clr) begin
               pre_q[u] <= 7'h0;
            end else if (src_tick[u]) begin
               pre_q[u] <= pre_q[u] + 7'h1;
            end
         end

         // A modulus of zero means the full 16-bit range
         assign lim[u] = (mod_q[u] == 16'h0) ? `TCCP_FULL_RANGE : mod_q[u];
         assign tof_ev[u] = tick[u] && (center_aligned_pwm_q[u] ? (!up_q[u] && cnt_q[u] <= 16'h1)
                                                  : (cnt_q[u] >= lim[u]));
         // Stopped unit takes new values at once so setup needs no period
         assign load[u] = tof_ev[u] || cs_q[u] == 2'(CS_OFF);

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               cnt_q[u] <= 16'h0;
               up_q[u] <= 1'b1;
            end else if (cnt_clr) begin
               cnt_q[u] <= 16'h0;
               up_q[u] <= 1'b1;
            end else if (tick[u]) begin
               if (!center_aligned_pwm_q[u]) begin
                  cnt_q[u] <= tof_ev[u] ? 16'h0 : cnt_q[u] + 16'h1;
                  up_q[u] <= 1'b1;
               end else if (up_q[u]) begin
                  if (cnt_q[u] >= lim[u]) begin
                     cnt_q[u] <= cnt_q[u] - 16'h1;
                     up_q[u] <= 1'b0;
                  end else begin
                     cnt_q[u] <= cnt_q[u] + 16'h1;
                  end
               end else if (tof_ev[u]) begin
                  cnt_q[u] <= 16'h0;
                  up_q[u] <= 1'b1;
               end else begin
                  cnt_q[u] <= cnt_q[u] - 16'h1;
               end
            end
         end

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               mod_buf_q[u] <= `TCCP_MOD_RST;
               mod_q[u] <= `TCCP_MOD_RST;
            end else begin
               if (BUS_IN.wr && BUS_IN.addr == A_MOD) begin
                  mod_buf_q[u] <= BUS_IN.wdata;
               end
               if (load[u]) begin
                  mod_q[u] <= (BUS_IN.wr && BUS_IN.addr == A_MOD) ? BUS_IN.wdata
                                                                  : mod_buf_q[u];
               end
            end
         end

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               upd_q[u] <= 1'b0;
            end else begin
               upd_q[u] <= tick[u] && !cnt_clr;
            end
         end

         sequence s_bottom;
            center_aligned_pwm_q[u] && tick[u] && !up_q[u] && cnt_q[u] <= 16'h1 && !cnt_clr;
         endsequence

         a_cnt_wrap: assert property (tick[u] && !center_aligned_pwm_q[u] && cnt_q[u] == lim[u] && !cnt_clr
            |=> cnt_q[u] == 16'h0) else $error("counter did not wrap at modulus");
         a_center_aligned_pwm_bottom: assert property (s_bottom |=> cnt_q[u] == 16'h0 && up_q[u]
            && sts_q[NCH+u]) else $error("centered period end wrong");
         a_pre_gate: assert property (tick[u] |-> src_tick[u] && cs_q[u] != 2'h0)
            else $error("count step without source clock");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // Channels: first N_CH_A belong to the one-channel unit
   logic [1:0] mode_q [NCH];
   logic [1:0] cfg_q [NCH];
   logic [15:0] val_q [NCH];
   logic [15:0] vbuf_q [NCH];
   logic [NCH-1:0] out_q;
   logic [NCH-1:0] ch_ev;
   logic [NCH-1:0] drive;

   generate
      for (genvar c = 0; c < NCH; c++) begin : g_ch
         localparam int U = (c < N_CH_A) ? 0 : 1;
         localparam logic [7:0] A_CTL = ch_addr(c, `TCCP_CHCTL_OFS);
         localparam logic [7:0] A_VAL = ch_addr(c, `TCCP_CHVAL_OFS);
         logic pwm_c;
         logic cap_ev;
         logic cmp_ev;
         logic val_wr;
         logic act;

         assign pwm_c = center_aligned_pwm_q[U] || mode_q[c][1];
         assign cap_ev = !pwm_c && mode_q[c] == 2'(MD_CAPTURE)
            && ((cfg_q[c][0] && rise[c]) || (cfg_q[c][1] && fall[c]));
         assign cmp_ev = upd_q[U] && cnt_q[U] == val_q[c];
         assign val_wr = BUS_IN.wr && BUS_IN.addr == A_VAL;
         assign act = cnt_q[U] < val_q[c];
         assign drive[c] = pwm_c || mode_q[c] == 2'(MD_COMPARE);
         assign ch_ev[c] = cap_ev || (drive[c] && cmp_ev);

         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               mode_q[c] <= 2'h0;
               cfg_q[c] <= 2'h0;
            end else if (BUS_IN.wr && BUS_IN.addr == A_CTL) begin
               mode_q[c] <= BUS_IN.wdata[`TCCP_CHCTL_MODE_LSB +: 2];
               cfg_q[c] <= BUS_IN.wdata[`TCCP_CHCTL_CFG_LSB +: 2];
            end
         end

         // PWM values wait in the buffer so a running period stays clean
         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               vbuf_q[c] <= `TCCP_VAL_RST;
               val_q[c] <= `TCCP_VAL_RST;
            end else begin
               if (val_wr) begin
                  vbuf_q[c] <= BUS_IN.wdata;
               end
               if (cap_ev) begin
                  val_q[c] <= cnt_q[U];
               end else if (!pwm_c && val_wr) begin
                  val_q[c] <= BUS_IN.wdata;
               end else if (pwm_c && load[U]) begin
                  val_q[c] <= val_wr ? BUS_IN.wdata : vbuf_q[c];
               end
            end
         end

         // cfg[0] set: active high PWM; compare: 1 clear, 2 set, else toggle
         always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
            if (!RST_B_IN) begin
               out_q[c] <= 1'b0;
            end else if (pwm_c) begin
               out_q[c] <= act ^ !cfg_q[c][0];
            end else if (mode_q[c] == 2'(MD_COMPARE) && cmp_ev) begin
               unique case (cfg_q[c])
                  2'h1: out_q[c] <= 1'b0;
                  2'h2: out_q[c] <= 1'b1;
                  default: out_q[c] <= !out_q[c];
               endcase
            end
         end

         a_cap_latch: assert property (cap_ev |=> val_q[c] == $past(cnt_q[U]))
            else $error("capture did not latch counter");
         a_buf_hold: assert property (pwm_c && !load[U] |=> val_q[c] == $past(val_q[c]))
            else $error("PWM value changed inside period");
         a_pin_dir: assert property (!drive[c] |-> CH_PIN_OE_B_OUT[c])
            else $error("capture pin driven");
      end
   endgenerate

   assign CH_PIN_OUT = out_q;
   assign CH_PIN_OE_B_OUT = ~drive;

   ////////////////////////////////////////////////////////////////////////////
   // Sticky status, write one to clear; a new event beats the clear
   logic [NST-1:0] mask_q;
   logic [NST-1:0] st_ev;
   logic [NST-1:0] st_clr;

   assign st_ev = {tof_ev[1], tof_ev[0], ch_ev};
   assign st_clr = (BUS_IN.wr && BUS_IN.addr == `TCCP_STS_ADDR) ? BUS_IN.wdata[NST-1:0]
                                                                : '0;

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         sts_q <= '0;
      end else begin
         sts_q <= (sts_q & ~st_clr) | st_ev;
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         mask_q <= '0;
      end else if (BUS_IN.wr && BUS_IN.addr == `TCCP_MASK_ADDR) begin
         mask_q <= BUS_IN.wdata[NST-1:0];
      end
   end

   assign IRQ_OUT = |(sts_q & mask_q);

   a_tof_flag: assert property (tof_ev[1] |=> sts_q[NCH+1])
      else $error("terminal count flag not set");
   a_irq_level: assert property (|(sts_q & mask_q) && !BUS_IN.wr |=> IRQ_OUT)
      else $error("masked-in flag did not raise interrupt");

   ////////////////////////////////////////////////////////////////////////////
   // Read port: data valid only in the cycle after the strobe
   logic [15:0] rd_d;
   logic [15:0] rdata_q;

   always_comb begin
      rd_d = 16'h0;
      if (BUS_IN.addr == `TCCP_STS_ADDR) begin
         rd_d = 16'(sts_q);
      end
      if (BUS_IN.addr == `TCCP_MASK_ADDR) begin
         rd_d = 16'(mask_q);
      end
      for (int u = 0; u < 2; u++) begin
         if (BUS_IN.addr == unit_addr(u, `TCCP_CTRL_OFS)) begin
            rd_d = {10'h0, center_aligned_pwm_q[u], ps_q[u], cs_q[u]};
         end
         if (BUS_IN.addr == unit_addr(u, `TCCP_MOD_OFS)) begin
            rd_d = mod_buf_q[u];
         end
         if (BUS_IN.addr == unit_addr(u, `TCCP_CNT_OFS)) begin
            rd_d = cnt_q[u];
         end
      end
      for (int c = 0; c < NCH; c++) begin
         if (BUS_IN.addr == ch_addr(c, `TCCP_CHCTL_OFS)) begin
            rd_d = {12'h0, cfg_q[c], mode_q[c]};
         end
         if (BUS_IN.addr == ch_addr(c, `TCCP_CHVAL_OFS)) begin
            rd_d = val_q[c];
         end
      end
   end

   always_ff @(posedge CLK_IN or negedge RST_B_IN) begin
      if (!RST_B_IN) begin
         rdata_q <= 16'h0;
      end else begin
         rdata_q <= BUS_IN.rd ? rd_d : 16'h0;
      end
   end

   assign RDATA_OUT = rdata_q;

   a_rd_status: assert property (BUS_IN.rd && BUS_IN.addr == `TCCP_STS_ADDR
      |=> RDATA_OUT == 16'($past(sts_q))) else $error("status read wrong");
endmodule : tccp_top

// File: tccp_pin_model.sv
// Far-side model: channel pin drivers and the external count clocks
`timescale 1ns/1ps
module tccp_pin_model #(
   parameter int HALF = 4
) (
   input wire logic clk_in,
   input wire logic [4:0] pin_out_in,
   input wire logic [4:0] oe_b_in,
   input wire logic [4:0] drive_lvl_in,
   input wire logic run_clk_in,
   output logic [4:0] pin_lvl_out,
   output logic [1:0] ext_clk_out,
   output logic fixed_ref_out
);
   logic [7:0] div_q = 8'h00;
   logic lvl_q = 1'b0;
   ////////////////////////////////////////////////////////////////////////////
   // Pin level: the device wins while it drives, else the outside driver
   always_comb begin
      for (int i = 0; i < 5; i++) begin
         pin_lvl_out[i] = oe_b_in[i] ? drive_lvl_in[i] : pin_out_in[i];
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   // Clocks run at an eighth of the core rate, well below the quarter limit
   always @(posedge clk_in) begin
      if (!run_clk_in) begin
         div_q <= 8'h00;
         lvl_q <= 1'b0;
      end else if (div_q == 8'(HALF - 1)) begin
         div_q <= 8'h00;
         lvl_q <= ~lvl_q;
      end else begin
         div_q <= div_q + 8'h01;
      end
   end
   assign ext_clk_out = {2{lvl_q}};
   assign fixed_ref_out = lvl_q;
endmodule : tccp_pin_model

// File: tccp_top_bench.sv
// Self-checking bench of the two-unit timer block
`timescale 1ns/1ps
`include "tccp_consts.svh"
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin fail_count++; \
   $display("ERROR t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tccp_top_bench;
   import tccp_pkg::*;
   logic clk_in = 1'b0;
   logic rst_b = 1'b0;
   tccp_bus_t bus = '0;
   logic [15:0] rdata;
   logic irq;
   logic [4:0] pin_out;
   logic [4:0] oe_b;
   logic [4:0] pin_lvl;
   logic [4:0] drive_lvl = 5'h00;
   logic [1:0] ext_clk;
   logic fixed_ref;
   logic run_clk = 1'b0;
   int fail_count = 0;
   int samples_checked = 0;
   always #10 clk_in = ~clk_in;
   tccp_top u_dut (.CLK_IN(clk_in), .RST_B_IN(rst_b), .BUS_IN(bus), .RDATA_OUT(rdata),
      .IRQ_OUT(irq), .FIXED_REF_IN(fixed_ref), .EXT_CLK_IN(ext_clk), .CH_PIN_IN(pin_lvl),
      .CH_PIN_OUT(pin_out), .CH_PIN_OE_B_OUT(oe_b));
   tccp_pin_model u_pins (.clk_in(clk_in), .pin_out_in(pin_out), .oe_b_in(oe_b),
      .drive_lvl_in(drive_lvl), .run_clk_in(run_clk), .pin_lvl_out(pin_lvl),
      .ext_clk_out(ext_clk), .fixed_ref_out(fixed_ref));
   ////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] ua(input int u, input logic [7:0] o);
      return 8'(`TCCP_UNIT_BASE + u * `TCCP_UNIT_STRIDE + o);
   endfunction : ua
   function automatic logic [7:0] ca(input int c, input logic [7:0] o);
      return 8'(`TCCP_CH_BASE + c * `TCCP_CH_STRIDE + o);
   endfunction : ca
   function automatic logic [15:0] cv(input int cs, input int ps, input int cp);
      return 16'((cs << `TCCP_CTRL_CS_LSB) | (ps << `TCCP_CTRL_PS_LSB)
         | (cp << `TCCP_CTRL_CENTER_ALIGNED_PWM_BIT));
   endfunction : cv
   function automatic logic [15:0] chc(input int md, input int cfg);
      return 16'((md << `TCCP_CHCTL_MODE_LSB) | (cfg << `TCCP_CHCTL_CFG_LSB));
   endfunction : chc
   task automatic cyc(input int n);
      repeat (n) @(posedge clk_in);
      #1;
   endtask : cyc
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus <= '0;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [15:0] v);
      @(posedge clk_in);
      bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus <= '0;
      #1;
      v = rdata;
   endtask : rd
   task automatic chk_rd(input logic [7:0] a, input logic [15:0] e);
      logic [15:0] v;
      rd(a, v);
      `CHK(v, e)
   endtask : chk_rd
   // Two counter reads exactly d cycles apart
   task automatic diff(input int u, input int d, input logic [15:0] e);
      logic [15:0] a;
      logic [15:0] b;
      rd(ua(u, `TCCP_CNT_OFS), a);
      cyc(d - 2);
      rd(ua(u, `TCCP_CNT_OFS), b);
      `CHK(16'(b - a), e)
   endtask : diff
   task automatic hi_count(input int c, input int n, output logic [15:0] k);
      k = 16'h0000;
      repeat (n) begin
         @(posedge clk_in);
         #1;
         k = k + 16'(pin_out[c]);
      end
   endtask : hi_count
   task automatic complete_run;
      if (fail_count == 0 && samples_checked > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : complete_run
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      #(20 * 20000);
      fail_count++;
      complete_run();
   end
   initial begin
      logic [15:0] a;
      logic [15:0] b;
      logic [15:0] k;
      repeat (3) @(posedge clk_in);
      rst_b <= 1'b1;
      #1;
      `CHK(oe_b, 5'h1f)
      `CHK({rdata, irq, pin_out}, 22'h000000)
      chk_rd(8'h05, 16'h0000);
      chk_rd(8'h30, 16'h0000);
      wr(ua(0, `TCCP_CTRL_OFS), 16'hffc0);
      chk_rd(ua(0, `TCCP_CTRL_OFS), 16'h0000);
      wr(ua(0, `TCCP_MOD_OFS), 16'h1234);
      chk_rd(ua(0, `TCCP_MOD_OFS), 16'h1234);
      wr(ua(0, `TCCP_MOD_OFS), `TCCP_MOD_RST);
      for (int n = 0; n < 8; n++) begin
         wr(ua(0, `TCCP_CTRL_OFS), cv(1, n, 0));
         diff(0, 8 << n, 16'h0008);
      end
      // Terminal count, masking and clearing; stopped unit takes the modulus at once
      wr(ua(0, `TCCP_CTRL_OFS), cv(0, 0, 0));
      wr(ua(0, `TCCP_MOD_OFS), 16'h0009);
      wr(ua(0, `TCCP_CTRL_OFS), cv(1, 0, 0));
      cyc(25);
      diff(0, 10, 16'h0000);
      rd(`TCCP_STS_ADDR, a);
      `CHK(a[5], 1'b1)
      `CHK(irq, 1'b0)
      wr(`TCCP_MASK_ADDR, 16'h0020);
      cyc(1);
      `CHK(irq, 1'b1)
      wr(ua(0, `TCCP_CTRL_OFS), cv(0, 0, 0));
      wr(`TCCP_STS_ADDR, 16'h0020);
      cyc(1);
      `CHK(irq, 1'b0)
      wr(`TCCP_MASK_ADDR, 16'h0000);
      // Alternative count sources; the fixed one assumes a legal generator mode
      run_clk <= 1'b1;
      wr(ua(0, `TCCP_MOD_OFS), `TCCP_MOD_RST);
      wr(ua(0, `TCCP_CTRL_OFS), cv(3, 0, 0));
      cyc(20);
      diff(0, 80, 16'd10);
      wr(ua(0, `TCCP_CTRL_OFS), cv(2, 0, 0));
      cyc(20);
      diff(0, 80, 16'd5);
      chk_rd(ua(1, `TCCP_CNT_OFS), 16'h0000);
      // Capture on a frozen counter, every edge selection
      wr(ua(0, `TCCP_CTRL_OFS), cv(0, 0, 0));
      rd(ua(0, `TCCP_CNT_OFS), b);
      for (int s = 0; s < 4; s++) begin
         wr(ca(0, `TCCP_CHCTL_OFS), chc(0, s));
         wr(`TCCP_STS_ADDR, 16'h0001);
         drive_lvl[0] <= 1'b1;
         cyc(8);
         rd(`TCCP_STS_ADDR, a);
         `CHK(a[0], 1'(s))
         if (s[0]) chk_rd(ca(0, `TCCP_CHVAL_OFS), b);
         wr(`TCCP_STS_ADDR, 16'h0001);
         drive_lvl[0] <= 1'b0;
         cyc(8);
         rd(`TCCP_STS_ADDR, a);
         `CHK(a[0], 1'(s >> 1))
      end
      // Compare actions on the four-channel unit
      wr(ua(1, `TCCP_MOD_OFS), 16'd19);
      wr(ca(1, `TCCP_CHVAL_OFS), 16'd5);
      wr(ua(1, `TCCP_CTRL_OFS), cv(1, 0, 0));
      for (int s = 0; s < 3; s++) begin
         wr(ca(1, `TCCP_CHCTL_OFS), chc(1, (s == 1) ? 1 : 2));
         cyc(45);
         `CHK(pin_out[1], 1'(s != 1))
         `CHK(oe_b[1], 1'b0)
      end
      wr(ca(1, `TCCP_CHCTL_OFS), chc(1, 0));
      cyc(45);
      a[0] = pin_out[1];
      cyc(20);
      `CHK(pin_out[1], ~a[0])
      rd(`TCCP_STS_ADDR, a);
      `CHK(a[1], 1'b1)
      // Edge-aligned PWM, both polarities, then buffered value
      wr(ca(2, `TCCP_CHCTL_OFS), chc(2, 1));
      wr(ca(2, `TCCP_CHVAL_OFS), 16'd7);
      cyc(45);
      hi_count(2, 20, k);
      `CHK(k, 16'd7)
      wr(ca(2, `TCCP_CHCTL_OFS), chc(3, 0));
      cyc(5);
      hi_count(2, 20, k);
      `CHK(k, 16'd13)
      wr(ua(1, `TCCP_CNT_OFS), 16'h0000);
      wr(ca(2, `TCCP_CHVAL_OFS), 16'd3);
      chk_rd(ca(2, `TCCP_CHVAL_OFS), 16'd7);
      cyc(30);
      chk_rd(ca(2, `TCCP_CHVAL_OFS), 16'd3);
      // Centered mode on the whole four-channel unit
      wr(ca(2, `TCCP_CHCTL_OFS), chc(2, 1));
      wr(ua(1, `TCCP_CTRL_OFS), cv(1, 0, 1));
      cyc(45);
      `CHK(oe_b, 5'h01)
      rd(ua(1, `TCCP_CNT_OFS), a);
      cyc(17);
      rd(ua(1, `TCCP_CNT_OFS), b);
      `CHK(16'(a + b), 16'd19)
      diff(1, 38, 16'h0000);
      hi_count(2, 38, k);
      `CHK(k, 16'd5)
      rd(`TCCP_STS_ADDR, a);
      `CHK(a[6], 1'b1)
      wr(ua(1, `TCCP_CNT_OFS), 16'h0000);
      wr(ca(2, `TCCP_CHVAL_OFS), 16'd9);
      chk_rd(ca(2, `TCCP_CHVAL_OFS), 16'd3);
      cyc(45);
      chk_rd(ca(2, `TCCP_CHVAL_OFS), 16'd9);
      complete_run();
   end
endmodule : tccp_top_bench
